// ===== verilog/pbm_pkg.sv
// package for the port b upper pin mux: register map, fields, reset values
`default_nettype none
package pbm_pkg;
    // register word addresses (byte offsets, one aligned word each)
    localparam logic [7:0] PBM_OFF_PIN_DATA = 8'h00; // port_pin_data
    localparam logic [7:0] PBM_OFF_LATCH = 8'h04; // port_output_latch
    localparam logic [7:0] PBM_OFF_DIR = 8'h08; // port_direction
    localparam logic [7:0] PBM_OFF_INTERRUPT_CONTROL_MAIN = 8'h0c; // interrupt_control_main
    localparam logic [7:0] PBM_OFF_INTERRUPT_CONTROL_SECOND = 8'h10; // interrupt_control_second
    localparam logic [7:0] PBM_OFF_INTERRUPT_CONTROL_THIRD = 8'h14; // interrupt_control_third
    localparam logic [7:0] PBM_OFF_SEG_LOW = 8'h18; // segment_enable_low
    localparam logic [7:0] PBM_OFF_SEG_HIGH = 8'h1c; // segment_enable_high
    localparam logic [7:0] PBM_OFF_IRQ_STAT = 8'h20; // sticky event status
    localparam logic [7:0] PBM_OFF_IRQ_MASK = 8'h24; // event mask
    localparam logic [7:0] PBM_OFF_PERIPH = 8'h28; // peripheral pin control
    // field positions
    localparam int PBM_BIT_CHG_FLAG = 0; // pin_change_flag in main control
    localparam int PBM_BIT_CHG_IE = 3; // pin_change_irq_enable in main control
    localparam int PBM_BIT_PU_DIS_N = 7; // pullup_disable_n in second control
    localparam int PBM_BIT_CHG_PRIO = 0; // pin_change_priority in second control
    localparam int PBM_BIT_SEGMENT_DRIVE_ELEVEN = 3; // segment 11 in low segment enables
    localparam int PBM_BIT_SEGMENT_DRIVE_TWENTY_NINE = 5; // segment 29 in high segment enables
    localparam int PBM_BIT_CCP_OUT = 0; // periph: pin 3 compare/pwm enable
    localparam int PBM_BIT_PWM_A = 1; // periph: pin 3 channel a enable
    localparam int PBM_BIT_SHUT_TRI = 2; // periph: tri-state on shutdown
    // reset values
    localparam logic [7:0] PBM_RST_DIR = 8'hff; // all inputs
    localparam logic [7:0] PBM_RST_LATCH = 8'h00;
    localparam logic [7:0] PBM_RST_CTRL = 8'h00;
    localparam logic [7:0] PBM_RST_INTERRUPT_CONTROL_SECOND = 8'hff; // pull-ups off at power-on
    localparam logic [3:0] PBM_RST_NIBBLE = 4'h0;
    // event status bits
    localparam int PBM_EV_CHANGE = 0; // change flag set
    localparam int PBM_EV_SHUTDOWN = 1; // pwm shutdown began
    localparam int PBM_EV_W = 2;
    // change flag may be cleared one instruction cycle after a port access
    localparam int PBM_TCY_NS = 40;
    localparam int PBM_CLK_NS = 10;
    localparam int PBM_TCY_CYC = (PBM_TCY_NS + PBM_CLK_NS - 1) / PBM_CLK_NS;
    localparam logic [2:0] PBM_TCY_CYC_W = 3'(PBM_TCY_CYC);
    // bus answer states
    typedef enum logic [1:0] {
        PBM_ST_IDLE = 2'b01,
        PBM_ST_ACC = 2'b10
    } pbm_state_e;
endpackage : pbm_pkg
`default_nettype wire

// ===== verilog/pbm_sync.sv
// three-stage synchroniser for pin inputs, change accepted when stages 2 and 3 agree
`default_nettype none
module pbm_sync
    import pbm_pkg::*;
#(
    parameter int W = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, out_reg;
    logic [W-1:0] out_next;

    // per bit: stage one only feeds stage two
    genvar g;
    for (g = 0; g < W; g++) begin : g_bit
        always_comb begin
            out_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : out_reg[g];
        end
    end

    // registers only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            out_reg <= '0;
        end else if (ce) begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign dout = out_reg;
endmodule : pbm_sync
`default_nettype wire

// ===== verilog/pbm_port.sv
// port b upper pins 3..7: pin mux, register file over apb, change detect
// Functional notes
// - pin 3: ccp2 drives when output, else captures
// - channel a overrides data, tri-states on shutdown
// - pins 4-7: latch out or input with pull-up
// - segment 11/29 enable takes pin entirely
// - pin 5 feeds timer3 clock, timer1 gate unless segment 29 is enabled
// - pin 6 always feeds programming clock
// - pin 7 bidirectional programming data, own direction
// - don't-care functions ignore direction bit
// - input pins 7:4 compared to last read; here a port write also reloads the old value
// - mismatch keeps flag set; clear after cycle
// - pull-up off for outputs, off at reset
//
// Chosen here: the address map and the APB register port.
`default_nettype none
module pbm_port
    import pbm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:3] pin_in,
    output logic [7:3] pin_out,
    output logic [7:3] pin_oe,
    output logic [7:3] pin_pullup,
    output logic [7:3] pin_seg_en,
    input wire logic seg_eleven_drive,
    input wire logic seg_twenty_nine_drive,
    input wire logic ccp_two_out,
    input wire logic pwm_two_a_out,
    input wire logic pwm_shutdown,
    output logic ccp_two_capture_in,
    output logic time_measure_edge_two,
    output logic timer_three_clock_in,
    output logic timer_one_gate_in,
    output logic program_clock,
    input wire logic program_mode,
    input wire logic program_data_out,
    input wire logic program_data_oe,
    output logic program_data_in,
    output logic change_irq_high,
    output logic change_irq_low,
    output logic irq
);
    // synchronised pin levels
    logic [7:3] pin_sync;
    pbm_sync #(.W(5)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .din(pin_in),
        .dout(pin_sync)
    );

    // register state
    logic [7:3] latch_reg, latch_next; // output_latch_bits
    logic [7:3] dir_reg, dir_next; // direction_bits
    logic [7:0] interrupt_control_main_reg, interrupt_control_main_next;
    logic [7:0] interrupt_control_second_reg, interrupt_control_second_next;
    logic [7:0] interrupt_control_third_reg, interrupt_control_third_next;
    logic [7:0] seg_low_reg, seg_low_next;
    logic [7:0] seg_high_reg, seg_high_next;
    logic [2:0] periph_reg, periph_next;
    logic [PBM_EV_W-1:0] stat_reg, stat_next;
    logic [PBM_EV_W-1:0] mask_reg, mask_next;
    logic [3:0] old_reg, old_next; // pin value seen at last port access, read or write
    logic [2:0] hold_reg, hold_next; // cycles until flag may clear
    logic shut_reg, shut_next; // previous shutdown level
    logic [31:0] rdata_reg, rdata_next;
    pbm_state_e st_reg, st_next;

    // bus decode
    logic acc, wr, rd, port_acc, mapped;
    logic [3:0] mismatch;
    logic [7:3] pin_data_bits;
    logic segment_drive_eleven_on, segment_drive_twenty_nine_on;

    always_comb begin
        acc = psel && penable && (st_reg == PBM_ST_ACC);
        wr = acc && pwrite;
        // reads are decoded in the setup cycle so prdata stands at the pready edge
        rd = psel && !penable && !pwrite && (st_reg == PBM_ST_IDLE);
        port_acc = acc && (paddr == PBM_OFF_PIN_DATA);
        mapped = (paddr <= PBM_OFF_PERIPH) && (paddr[1:0] == 2'b00);
    end

    assign segment_drive_eleven_on = seg_low_reg[PBM_BIT_SEGMENT_DRIVE_ELEVEN];
    assign segment_drive_twenty_nine_on = seg_high_reg[PBM_BIT_SEGMENT_DRIVE_TWENTY_NINE];
    assign pin_data_bits = pin_sync;

    // input pins 7:4 against the value at the last port access, read or write; outputs excluded
    always_comb begin
        mismatch = (pin_sync[7:4] ^ old_reg) & dir_reg[7:4];
    end

    // apb setup/access: one wait-free access cycle
    always_comb begin
        case (st_reg)
            PBM_ST_IDLE: st_next = (psel && !penable) ? PBM_ST_ACC : PBM_ST_IDLE;
            PBM_ST_ACC: st_next = PBM_ST_IDLE;
            default: st_next = PBM_ST_IDLE;
        endcase
        if (!psel) begin
            st_next = PBM_ST_IDLE;
        end
    end

    // register writes and hardware updates
    always_comb begin
        latch_next = latch_reg;
        dir_next = dir_reg;
        interrupt_control_main_next = interrupt_control_main_reg;
        interrupt_control_second_next = interrupt_control_second_reg;
        interrupt_control_third_next = interrupt_control_third_reg;
        seg_low_next = seg_low_reg;
        seg_high_next = seg_high_reg;
        periph_next = periph_reg;
        mask_next = mask_reg;
        stat_next = stat_reg;
        old_next = old_reg;
        hold_next = (hold_reg != 3'h0) ? hold_reg - 3'h1 : hold_reg;
        shut_next = pwm_shutdown;
        if (wr) begin
            case (paddr)
                PBM_OFF_PIN_DATA: latch_next = pwdata[7:3]; // port write goes to latch
                PBM_OFF_LATCH: latch_next = pwdata[7:3];
                PBM_OFF_DIR: dir_next = pwdata[7:3];
                PBM_OFF_INTERRUPT_CONTROL_MAIN: begin
                    // flag clear only after the settle delay
                    interrupt_control_main_next = pwdata[7:0];
                    if (hold_reg != 3'h0) begin
                        interrupt_control_main_next[PBM_BIT_CHG_FLAG] = interrupt_control_main_reg[PBM_BIT_CHG_FLAG];
                    end
                end
                PBM_OFF_INTERRUPT_CONTROL_SECOND: interrupt_control_second_next = pwdata[7:0];
                PBM_OFF_INTERRUPT_CONTROL_THIRD: interrupt_control_third_next = pwdata[7:0];
                PBM_OFF_SEG_LOW: seg_low_next = pwdata[7:0];
                PBM_OFF_SEG_HIGH: seg_high_next = pwdata[7:0];
                PBM_OFF_IRQ_STAT: stat_next = stat_reg & ~pwdata[PBM_EV_W-1:0];
                PBM_OFF_IRQ_MASK: mask_next = pwdata[PBM_EV_W-1:0];
                PBM_OFF_PERIPH: periph_next = pwdata[2:0];
                default: ;
            endcase
        end
        // any port access ends the mismatch and starts the settle delay
        if (port_acc) begin
            // a read keeps what software saw, so no change slips between setup and access
            old_next = pwrite ? pin_sync[7:4] : rdata_reg[7:4];
            hold_next = PBM_TCY_CYC_W;
        end
        // set wins over software clear
        if (|mismatch) begin
            interrupt_control_main_next[PBM_BIT_CHG_FLAG] = 1'b1;
            stat_next[PBM_EV_CHANGE] = 1'b1;
        end
        if (pwm_shutdown && !shut_reg) begin
            stat_next[PBM_EV_SHUTDOWN] = 1'b1;
        end
    end

    // read mux, loaded at the setup edge; held in flip-flops through the access cycle
    always_comb begin
        rdata_next = rdata_reg;
        if (rd) begin
            case (paddr)
                PBM_OFF_PIN_DATA: rdata_next = {24'h0, pin_data_bits, 3'h0};
                PBM_OFF_LATCH: rdata_next = {24'h0, latch_reg, 3'h0};
                PBM_OFF_DIR: rdata_next = {24'h0, dir_reg, 3'h0};
                PBM_OFF_INTERRUPT_CONTROL_MAIN: rdata_next = {24'h0, interrupt_control_main_reg};
                PBM_OFF_INTERRUPT_CONTROL_SECOND: rdata_next = {24'h0, interrupt_control_second_reg};
                PBM_OFF_INTERRUPT_CONTROL_THIRD: rdata_next = {24'h0, interrupt_control_third_reg};
                PBM_OFF_SEG_LOW: rdata_next = {24'h0, seg_low_reg};
                PBM_OFF_SEG_HIGH: rdata_next = {24'h0, seg_high_reg};
                PBM_OFF_IRQ_STAT: rdata_next = {30'h0, stat_reg};
                PBM_OFF_IRQ_MASK: rdata_next = {30'h0, mask_reg};
                PBM_OFF_PERIPH: rdata_next = {29'h0, periph_reg};
                default: rdata_next = 32'h0;
            endcase
        end
    end

    // registers only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_reg <= PBM_RST_LATCH[7:3];
            dir_reg <= PBM_RST_DIR[7:3];
            interrupt_control_main_reg <= PBM_RST_CTRL;
            interrupt_control_second_reg <= PBM_RST_INTERRUPT_CONTROL_SECOND;
            interrupt_control_third_reg <= PBM_RST_CTRL;
            seg_low_reg <= PBM_RST_CTRL;
            seg_high_reg <= PBM_RST_CTRL;
            periph_reg <= PBM_RST_CTRL[2:0];
            stat_reg <= '0;
            mask_reg <= '0;
            old_reg <= PBM_RST_NIBBLE;
            hold_reg <= 3'h0;
            shut_reg <= 1'b0;
            rdata_reg <= 32'h0;
            st_reg <= PBM_ST_IDLE;
        end else if (ce) begin
            latch_reg <= latch_next;
            dir_reg <= dir_next;
            interrupt_control_main_reg <= interrupt_control_main_next;
            interrupt_control_second_reg <= interrupt_control_second_next;
            interrupt_control_third_reg <= interrupt_control_third_next;
            seg_low_reg <= seg_low_next;
            seg_high_reg <= seg_high_next;
            periph_reg <= periph_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            old_reg <= old_next;
            hold_reg <= hold_next;
            shut_reg <= shut_next;
            rdata_reg <= rdata_next;
            st_reg <= st_next;
        end
    end

    assign prdata = rdata_reg;
    assign pready = (st_reg == PBM_ST_ACC);
    assign pslverr = pready && psel && penable && !mapped;

    // pin 3 function priority: channel a, then compare/pwm, then latch
    logic p3_drive, p3_out;
    always_comb begin
        p3_out = latch_reg[3];
        p3_drive = !dir_reg[3];
        if (!dir_reg[3] && periph_reg[PBM_BIT_PWM_A]) begin
            p3_out = pwm_two_a_out;
            p3_drive = !(pwm_shutdown && periph_reg[PBM_BIT_SHUT_TRI]);
        end else if (!dir_reg[3] && periph_reg[PBM_BIT_CCP_OUT]) begin
            p3_out = ccp_two_out;
        end
    end

    // pins 4..7: latch, segment override, programming data on 7
    always_comb begin
        pin_out = {latch_reg[7:4], p3_out};
        pin_oe = {~dir_reg[7:4], p3_drive};
        pin_seg_en = 5'h0;
        if (program_mode) begin
            pin_out[7] = program_data_out;
            pin_oe[7] = program_data_oe;
            pin_oe[6] = 1'b0;
        end
        if (segment_drive_eleven_on) begin
            pin_oe[4] = 1'b0;
            pin_seg_en[4] = seg_eleven_drive;
        end
        if (segment_drive_twenty_nine_on) begin
            pin_oe[5] = 1'b0;
            pin_seg_en[5] = seg_twenty_nine_drive;
        end
    end

    // pull-ups: enable bit low, pin an input, pin not a segment
    always_comb begin
        pin_pullup = (interrupt_control_second_reg[PBM_BIT_PU_DIS_N] ? 5'h0 : dir_reg) & ~pin_oe;
        pin_pullup[4] = pin_pullup[4] && !segment_drive_eleven_on;
        pin_pullup[5] = pin_pullup[5] && !segment_drive_twenty_nine_on;
    end

    // peripheral inputs ignore direction bits, except ccp2 capture, which reads 0 unless pin 3 is an input
    assign ccp_two_capture_in = dir_reg[3] ? pin_sync[3] : 1'b0;
    assign time_measure_edge_two = pin_sync[3];
    assign timer_three_clock_in = segment_drive_twenty_nine_on ? 1'b0 : pin_sync[5];
    assign timer_one_gate_in = segment_drive_twenty_nine_on ? 1'b0 : pin_sync[5];
    assign program_clock = pin_sync[6];
    assign program_data_in = pin_sync[7];

    // change request gated by enable, split by priority
    logic chg_req;
    assign chg_req = interrupt_control_main_reg[PBM_BIT_CHG_FLAG] && interrupt_control_main_reg[PBM_BIT_CHG_IE];
    assign change_irq_high = chg_req && interrupt_control_second_reg[PBM_BIT_CHG_PRIO];
    assign change_irq_low = chg_req && !interrupt_control_second_reg[PBM_BIT_CHG_PRIO];
    assign irq = |(stat_reg & mask_reg);

    // checks
    a_mismatch_sets: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && |mismatch) |=> interrupt_control_main_reg[PBM_BIT_CHG_FLAG])
        else $error("change flag not set on mismatch");
    a_pin3_output: assert property (@(posedge pclk) disable iff (!presetn)
        (!dir_reg[3] && periph_reg[PBM_BIT_CCP_OUT] && !periph_reg[PBM_BIT_PWM_A])
        |-> (pin_out[3] == ccp_two_out))
        else $error("pin 3 not driven by compare output");
    a_pwm_tristate: assert property (@(posedge pclk) disable iff (!presetn)
        (!dir_reg[3] && periph_reg[PBM_BIT_PWM_A] && pwm_shutdown
         && periph_reg[PBM_BIT_SHUT_TRI]) |-> !pin_oe[3])
        else $error("pin 3 driven during shutdown");
    a_latch_drive: assert property (@(posedge pclk) disable iff (!presetn)
        (!dir_reg[6] && !program_mode) |-> (pin_oe[6] && pin_out[6] == latch_reg[6]))
        else $error("pin 6 not driving latch");
    a_segment_takes: assert property (@(posedge pclk) disable iff (!presetn)
        segment_drive_eleven_on |-> (!pin_oe[4] && !pin_pullup[4]))
        else $error("pin 4 not released to segment");
    a_timer_feed: assert property (@(posedge pclk) disable iff (!presetn)
        !segment_drive_twenty_nine_on |-> (timer_three_clock_in == pin_sync[5]))
        else $error("timer clock not following pin 5");
    a_prog_data: assert property (@(posedge pclk) disable iff (!presetn)
        program_mode |-> (pin_oe[7] == program_data_oe))
        else $error("pin 7 direction not from programming");
    a_output_no_pull: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_oe[5]) |-> !pin_pullup[5])
        else $error("pull-up on an output pin");
    a_clear_held: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && wr && paddr == PBM_OFF_INTERRUPT_CONTROL_MAIN && hold_reg != 3'h0
         && interrupt_control_main_reg[PBM_BIT_CHG_FLAG]) |=> interrupt_control_main_reg[PBM_BIT_CHG_FLAG])
        else $error("change flag cleared too early");
    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !interrupt_control_main_reg[PBM_BIT_CHG_IE] |-> !(change_irq_high || change_irq_low))
        else $error("change request without enable");
endmodule : pbm_port
`default_nettype wire

// ===== testbench/pbm_pins_model.sv
// behavioural model of the pads and outside world on pins 3..7
`default_nettype none
module pbm_pins_model (
    input wire logic pclk,
    input wire logic [7:3] pin_out,
    input wire logic [7:3] pin_oe,
    input wire logic [7:3] pin_pullup,
    input wire logic [7:3] ext_level,
    input wire logic [7:3] ext_drive,
    output logic [7:3] pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:3] float_reg = 5'h00; // level of a pin nobody drives
    // an undriven pin wanders every cycle, so a stale value never passes
    always @(posedge pclk) begin
        float_reg <= ~float_reg;
    end
    // pad level: block drive wins, then outside drive, then pull-up
    always_comb begin
        for (int i = 3; i <= 7; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_drive[i]) begin
                pin_in[i] = ext_level[i];
            end else if (pin_pullup[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = float_reg[i];
            end
        end
    end
endmodule : pbm_pins_model
`default_nettype wire

// ===== testbench/test_port_b_upper_pin_mux.sv
// self-checking bench for the port b upper pin mux
`default_nettype none
module test_port_b_upper_pin_mux
    import pbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic [7:3] pin_in, pin_out, pin_oe, pin_pullup, pin_seg_en, ext_level, ext_drive;
    logic ccp_two_out, pwm_two_a_out, pwm_shutdown, program_mode, program_data_out;
    logic program_data_oe, ccp_two_capture_in, time_measure_edge_two, timer_three_clock_in;
    logic timer_one_gate_in, program_clock, program_data_in, change_irq_high, change_irq_low, irq;
    int bad_count = 0; // mismatches seen
    int n_checks = 0; // comparisons made
    pbm_port uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .pin_seg_en(pin_seg_en), .seg_eleven_drive(1'b1),
        .seg_twenty_nine_drive(1'b1), .ccp_two_out(ccp_two_out), .pwm_two_a_out(pwm_two_a_out),
        .pwm_shutdown(pwm_shutdown), .ccp_two_capture_in(ccp_two_capture_in),
        .time_measure_edge_two(time_measure_edge_two), .timer_three_clock_in(timer_three_clock_in),
        .timer_one_gate_in(timer_one_gate_in), .program_clock(program_clock),
        .program_mode(program_mode), .program_data_out(program_data_out),
        .program_data_oe(program_data_oe), .program_data_in(program_data_in),
        .change_irq_high(change_irq_high), .change_irq_low(change_irq_low), .irq(irq));
    pbm_pins_model pads (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_level(ext_level), .ext_drive(ext_drive), .pin_in(pin_in));
    // free-running 100 mhz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // verdict and end of run, from one place only
    task complete_run;
        if (bad_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    // compare seen against expected, four-state exact
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // let n edges pass, then step off the edge so outputs have settled
    task automatic step(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : step
    // one apb transfer; setup, then access held until pready at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic err);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        // response and read data are taken at the completing edge only
        err = pslverr;
        r = prdata;
        if (i == 16) begin
            bad_count++;
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd_data, rd_err);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd_data, rd_err);
        check(rd_data, exp);
    endtask : rdc
    // reset state and an unmapped address
    task automatic t_reset;
        check(32'(pin_oe), 32'h0);
        check(32'(pin_pullup), 32'h0);
        rdc(PBM_OFF_DIR, 32'hf8);
        rdc(PBM_OFF_INTERRUPT_CONTROL_SECOND, 32'hff);
        apb(1'b0, 8'h40, 32'h0, rd_data, rd_err);
        check(32'(rd_err), 32'h1);
        check(rd_data, 32'h0);
    endtask : t_reset
    // latch drive, pull-ups only on inputs, timer and clock taps
    task automatic t_pins;
        wr(PBM_OFF_INTERRUPT_CONTROL_SECOND, 32'h00);
        wr(PBM_OFF_LATCH, 32'ha0);
        wr(PBM_OFF_DIR, 32'h08);
        check(32'(pin_oe), 32'h1e);
        check(32'(pin_out[7:4]), 32'ha);
        check(32'(pin_pullup), 32'h01);
        step(8);
        check(32'(timer_three_clock_in), 32'h1);
        check(32'(timer_one_gate_in), 32'h1);
        check(32'(program_clock), 32'h0);
        wr(PBM_OFF_LATCH, 32'h40);
        step(8);
        check(32'(timer_three_clock_in), 32'h0);
        check(32'(program_clock), 32'h1);
    endtask : t_pins
    // pin 3 peripheral overrides, shutdown tri-state, capture path
    task automatic t_periph;
        wr(PBM_OFF_LATCH, 32'h08);
        wr(PBM_OFF_PERIPH, 32'h01);
        wr(PBM_OFF_DIR, 32'h00);
        check(32'({pin_oe[3], pin_out[3]}), 32'h2);
        ccp_two_out <= 1'b1;
        step(1);
        check(32'(pin_out[3]), 32'h1);
        wr(PBM_OFF_PERIPH, 32'h06);
        check(32'({pin_oe[3], pin_out[3]}), 32'h2);
        wr(PBM_OFF_IRQ_STAT, 32'h03);
        pwm_shutdown <= 1'b1;
        step(1);
        check(32'(pin_oe[3]), 32'h0);
        pwm_shutdown <= 1'b0;
        rdc(PBM_OFF_IRQ_STAT, 32'h02);
        wr(PBM_OFF_PERIPH, 32'h00);
        wr(PBM_OFF_DIR, 32'h08);
        ext_drive <= 5'h01;
        ext_level <= 5'h01;
        step(8);
        check(32'(ccp_two_capture_in), 32'h1);
        check(32'(time_measure_edge_two), 32'h1);
        ext_level <= 5'h00;
        step(8);
        check(32'(ccp_two_capture_in), 32'h0);
    endtask : t_periph
    // segment enables route the pin to its segment and drop the output enable
    task automatic t_segment;
        wr(PBM_OFF_DIR, 32'h00);
        wr(PBM_OFF_SEG_LOW, 32'h08);
        check(32'(pin_seg_en), 32'h02);
        check(32'(pin_oe[4]), 32'h0);
        wr(PBM_OFF_SEG_LOW, 32'h00);
        wr(PBM_OFF_SEG_HIGH, 32'h20);
        check(32'(pin_seg_en), 32'h04);
        check(32'(pin_oe[5]), 32'h0);
        wr(PBM_OFF_SEG_HIGH, 32'h00);
    endtask : t_segment
    // debug data line sets its own direction
    task automatic t_program;
        wr(PBM_OFF_DIR, 32'h80);
        program_mode <= 1'b1;
        program_data_out <= 1'b1;
        program_data_oe <= 1'b1;
        step(1);
        check(32'({pin_oe[7], pin_out[7]}), 32'h3);
        wr(PBM_OFF_DIR, 32'h00);
        program_data_oe <= 1'b0;
        ext_drive <= 5'h10;
        ext_level <= 5'h10;
        step(8);
        check(32'(pin_oe[7]), 32'h0);
        check(32'(program_data_in), 32'h1);
        program_mode <= 1'b0;
    endtask : t_program
    // change detect, guarded clear, routing, mask and sticky status
    task automatic t_change;
        wr(PBM_OFF_DIR, 32'hf8);
        ext_drive <= 5'h1f;
        ext_level <= 5'h00;
        step(8);
        rdc(PBM_OFF_PIN_DATA, 32'h00);
        step(5);
        wr(PBM_OFF_INTERRUPT_CONTROL_MAIN, 32'h08);
        wr(PBM_OFF_IRQ_MASK, 32'h01);
        wr(PBM_OFF_IRQ_STAT, 32'h03);
        check(32'({change_irq_high, change_irq_low, irq}), 32'h0);
        ext_level <= 5'h02;
        step(8);
        rdc(PBM_OFF_INTERRUPT_CONTROL_MAIN, 32'h09);
        check(32'({change_irq_high, change_irq_low, irq}), 32'h3);
        wr(PBM_OFF_INTERRUPT_CONTROL_SECOND, 32'h01);
        check(32'({change_irq_high, change_irq_low}), 32'h2);
        wr(PBM_OFF_IRQ_MASK, 32'h00);
        check(32'(irq), 32'h0);
        step(5);
        wr(PBM_OFF_INTERRUPT_CONTROL_MAIN, 32'h08);
        rdc(PBM_OFF_INTERRUPT_CONTROL_MAIN, 32'h09);
        rdc(PBM_OFF_PIN_DATA, 32'h10);
        wr(PBM_OFF_INTERRUPT_CONTROL_MAIN, 32'h08);
        rdc(PBM_OFF_INTERRUPT_CONTROL_MAIN, 32'h09);
        step(5);
        wr(PBM_OFF_INTERRUPT_CONTROL_MAIN, 32'h08);
        rdc(PBM_OFF_INTERRUPT_CONTROL_MAIN, 32'h08);
        wr(PBM_OFF_IRQ_STAT, 32'h01);
        wr(PBM_OFF_DIR, 32'he8);
        step(8);
        rdc(PBM_OFF_INTERRUPT_CONTROL_MAIN, 32'h08);
    endtask : t_change
    // hang guard
    initial begin
        repeat (50000) @(posedge pclk);
        bad_count++;
        complete_run();
    end
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {ccp_two_out, pwm_two_a_out, pwm_shutdown} = 3'h0;
        {program_mode, program_data_out, program_data_oe} = 3'h0;
        ext_level = 5'h00;
        ext_drive = 5'h00;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        step(1);
        t_reset();
        t_pins();
        t_periph();
        t_segment();
        t_program();
        t_change();
        complete_run();
    end
endmodule : test_port_b_upper_pin_mux
`default_nettype wire
